// File: pps_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module pps_drive_model import pps_pkg::*; #(
	parameter int STEP = 500
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Commands from the sequencer
	input wire logic motorRun,
	input wire logic pidTakeover,
	input wire logic [FIELD_W-1:0] freqCmd,
	input wire logic [FIELD_W-1:0] upperFreq,
	// Measured output frequency
	output logic [FIELD_W-1:0] runFreq
);
	logic [FIELD_W-1:0] target;
	// A starved pipe saturates the regulator at the upper limit
	assign target = !motorRun ? 16'h0000 : (pidTakeover ? upperFreq : freqCmd);
	// Limited slew, so a hold at the fill frequency starts late
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			runFreq <= 16'h0000;
		end else if (32'(runFreq) + STEP <= 32'(target)) begin
			runFreq <= runFreq + FIELD_W'(STEP);
		end else if (32'(target) + STEP <= 32'(runFreq)) begin
			runFreq <= runFreq - FIELD_W'(STEP);
		end else begin
			runFreq <= target;
		end
	end
endmodule
`default_nettype wire

// File: pps_pkg.sv
`default_nettype none
package pps_pkg;
	// Clock and timebase
	localparam int CLK_FREQ_HZ = 20_000_000;
	localparam int TICK_TIME_MS = 100;
	localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
	localparam int TIMER_W = 16;
	localparam int FIELD_W = 16;
	localparam int TERM_COUNT = 4;

	// Condensation injection time
	localparam int CONDENSE_TIME_S = 40;
	localparam logic [15:0] CONDENSE_TICKS = 16'(CONDENSE_TIME_S * 1000 / TICK_TIME_MS);

	// Terminal function codes
	localparam logic [7:0] FUNC_PUMP_CLEAN = 8'h56;
	localparam logic [7:0] FUNC_CONDENSE = 8'h5B;

	// Reported temperature span, 0.1 degC
	localparam logic signed [15:0] TEMP_MIN = 16'shFF38;
	localparam logic signed [15:0] TEMP_MAX = 16'sh07D0;

	// APB byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TERM_FUNC = 8'h04;
	localparam logic [7:0] OFS_CLEAN_FREQ = 8'h08;
	localparam logic [7:0] OFS_CLEAN_RAMP = 8'h0C;
	localparam logic [7:0] OFS_CLEAN_DUR = 8'h10;
	localparam logic [7:0] OFS_CLEAN_DWELL = 8'h14;
	localparam logic [7:0] OFS_PIPE_BREAK = 8'h18;
	localparam logic [7:0] OFS_SOFT_FILL = 8'h1C;
	localparam logic [7:0] OFS_FILL_FREEZE = 8'h20;
	localparam logic [7:0] OFS_TEMP_THR = 8'h24;
	localparam logic [7:0] OFS_CONDENSE = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;

	// CTRL fields
	localparam int CTRL_PIPE_ACTION = 0;
	localparam int CTRL_FILL_EN = 1;
	localparam int CTRL_FREEZE_EN = 2;
	localparam int CTRL_SENSOR_LSB = 4;

	// Reset values; freq 0.01 Hz, time 0.1 s, level 0.1 %, temp 0.1 degC
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_TERM_FUNC = 32'h0000_0000;
	localparam logic [31:0] RST_CLEAN_FREQ = 32'h0BB8_1388;
	localparam logic [31:0] RST_CLEAN_RAMP = 32'h0064_0064;
	localparam logic [31:0] RST_CLEAN_DUR = 32'h0032_0032;
	localparam logic [31:0] RST_CLEAN_DWELL = 32'h0001_000A;
	localparam logic [31:0] RST_PIPE_BREAK = 32'h04B0_0064;
	localparam logic [31:0] RST_SOFT_FILL = 32'h0064_0BB8;
	localparam logic [31:0] RST_FILL_FREEZE = 32'h0000_012C;
	localparam logic [31:0] RST_TEMP_THR = 32'h0000_FFCE;
	localparam logic [31:0] RST_CONDENSE = 32'h0000_012C;

	typedef enum logic [2:0] {
		ST_IDLE, ST_CLEAN_FWD, ST_CLEAN_DWELL_A, ST_CLEAN_REV, ST_CLEAN_DWELL_B, ST_FILL, ST_RUN, ST_FREEZE
	} pps_state_e;
endpackage
`default_nettype wire

// File: pps_sequencer.sv
// How it works
// - Cleaning starts from stop only with a code-86 terminal asserted and a start command.
// - Cleaning runs forward, dwells, runs reverse, dwells, repeating for the cycle count.
// - Cleaning ramp times are settable 0 to 3600.0 s, default 10.0 s.
// - Forward, reverse and dwell times settable 1.0 to 1000.0 s; runs default 5.0 s.
// - After the last cycle the sequencer returns to stop by itself.
// - A stop command aborts cleaning at once.
// - Pipe-break action 0 keeps running, 1 stops the motor.
// - Frequency at upper limit and feedback short by level for detection time means break.
// - Break level 0.0 to 100.0 %, default 10.0 %; zero disables detection.
// - With soft fill enabled every startup fills before closed-loop control.
// - Filling runs at the fill frequency and ends after holding it for the duration.
// - Filling also ends once feedback reaches the cutoff level.
// - On either fill exit the PID regulator takes the frequency.
// - A fault during filling makes the next restart fill again.
// - Enabled and below freezing threshold: raise freeze signal, run at freeze frequency.
// - A drive already running normally ignores freeze activation.
// - A run command during freeze protection ends it and runs normally.
// - Stop during freeze stops and disarms; re-arms once temperature exceeds threshold.
// - Pre-alarm is on whenever temperature is below the pre-alarm threshold.
// - Temperature reported within -20.0 to 200.0; out of range reads zero.
// - A code-91 terminal edge injects DC at the set level for 40 s; retrigger needs new edge.
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer import pps_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Operator commands and terminals
	input wire logic runCmd,
	input wire logic stopCmd,
	input wire logic faultStop,
	input wire logic [TERM_COUNT-1:0] termIn,
	// Process measurements
	input wire logic [FIELD_W-1:0] pidFeedback,
	input wire logic [FIELD_W-1:0] pidSetpoint,
	input wire logic [FIELD_W-1:0] runFreq,
	input wire logic [FIELD_W-1:0] upperFreq,
	input wire logic signed [15:0] tempRaw,
	// Motor commands
	output logic motorRun,
	output logic motorReverse,
	output logic [FIELD_W-1:0] freqCmd,
	output logic [FIELD_W-1:0] accelTime,
	output logic [FIELD_W-1:0] decelTime,
	output logic pidTakeover,
	output logic dcInject,
	output logic [FIELD_W-1:0] dcLevel,
	// Status and alarms
	output logic cleanActive,
	output logic fillActive,
	output logic freezeSignal,
	output logic prealarm,
	output logic pipeBreakAlarm,
	output logic signed [15:0] tempReport
);
	logic [31:0] ctrl_q, termFunc_q, cleanFreq_q, cleanRamp_q, cleanDur_q, cleanDwell_q;
	logic [31:0] pipeBreak_q, softFill_q, fillFreeze_q, tempThr_q, condense_q;
	logic [31:0] prdata_q, rdVal;
	logic rdHit, wrEn;
	pps_state_e state_q, state_d;
	logic tick, stateChange;
	logic [TIMER_W-1:0] stateCnt, pipeCnt, fillCnt, condCnt;
	logic [7:0] cycle_q;
	logic cleanBlock_q, freezeArmed_q, condPrev_q, condRun_q;
	logic cleanTerm, condTerm, condRise, condDone;
	logic pipeCond, pipeTrip, fillHold, fillExit, freezeCond;
	logic signed [15:0] tempVal, freezeThr, preThr;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// A terminal counts when its assigned function code matches and it is asserted
	function automatic logic termActive(input logic [31:0] codes, input logic [TERM_COUNT-1:0] pins,
		input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < TERM_COUNT; i++) begin
			if (codes[i*8 +: 8] == code && pins[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic logic isCleaning(input pps_state_e s);
		return s == ST_CLEAN_FWD || s == ST_CLEAN_DWELL_A || s == ST_CLEAN_REV || s == ST_CLEAN_DWELL_B;
	endfunction

	// Bus slave: read data is captured in the setup phase so the access phase answers at once
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign wrEn = psel && penable && pwrite && rdHit;
	assign pslverr = psel && penable && !rdHit;

	always_comb begin
		rdHit = 1'b1;
		rdVal = 32'h0;
		if (paddr == OFS_CTRL) begin
			rdVal = ctrl_q;
		end else if (paddr == OFS_TERM_FUNC) begin
			rdVal = termFunc_q;
		end else if (paddr == OFS_CLEAN_FREQ) begin
			rdVal = cleanFreq_q;
		end else if (paddr == OFS_CLEAN_RAMP) begin
			rdVal = cleanRamp_q;
		end else if (paddr == OFS_CLEAN_DUR) begin
			rdVal = cleanDur_q;
		end else if (paddr == OFS_CLEAN_DWELL) begin
			rdVal = cleanDwell_q;
		end else if (paddr == OFS_PIPE_BREAK) begin
			rdVal = pipeBreak_q;
		end else if (paddr == OFS_SOFT_FILL) begin
			rdVal = softFill_q;
		end else if (paddr == OFS_FILL_FREEZE) begin
			rdVal = fillFreeze_q;
		end else if (paddr == OFS_TEMP_THR) begin
			rdVal = tempThr_q;
		end else if (paddr == OFS_CONDENSE) begin
			rdVal = condense_q;
		end else if (paddr == OFS_STATUS) begin
			rdVal = {tempReport, cycle_q, 1'b0, freezeArmed_q, cleanBlock_q, dcInject,
				pipeBreakAlarm, 3'(state_q)};
		end else begin
			rdHit = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_q <= 32'h0;
		end else if (psel && !penable) begin
			prdata_q <= rdVal;
		end
	end

	// Status is read-only; writes to it are accepted and dropped
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_q <= RST_CTRL;
			termFunc_q <= RST_TERM_FUNC;
			cleanFreq_q <= RST_CLEAN_FREQ;
			cleanRamp_q <= RST_CLEAN_RAMP;
			cleanDur_q <= RST_CLEAN_DUR;
			cleanDwell_q <= RST_CLEAN_DWELL;
			pipeBreak_q <= RST_PIPE_BREAK;
			softFill_q <= RST_SOFT_FILL;
			fillFreeze_q <= RST_FILL_FREEZE;
			tempThr_q <= RST_TEMP_THR;
			condense_q <= RST_CONDENSE;
		end else if (wrEn) begin
			if (paddr == OFS_CTRL) begin
				ctrl_q <= wmerge(ctrl_q, pwdata, pstrb);
			end else if (paddr == OFS_TERM_FUNC) begin
				termFunc_q <= wmerge(termFunc_q, pwdata, pstrb);
			end else if (paddr == OFS_CLEAN_FREQ) begin
				cleanFreq_q <= wmerge(cleanFreq_q, pwdata, pstrb);
			end else if (paddr == OFS_CLEAN_RAMP) begin
				cleanRamp_q <= wmerge(cleanRamp_q, pwdata, pstrb);
			end else if (paddr == OFS_CLEAN_DUR) begin
				cleanDur_q <= wmerge(cleanDur_q, pwdata, pstrb);
			end else if (paddr == OFS_CLEAN_DWELL) begin
				cleanDwell_q <= wmerge(cleanDwell_q, pwdata, pstrb);
			end else if (paddr == OFS_PIPE_BREAK) begin
				pipeBreak_q <= wmerge(pipeBreak_q, pwdata, pstrb);
			end else if (paddr == OFS_SOFT_FILL) begin
				softFill_q <= wmerge(softFill_q, pwdata, pstrb);
			end else if (paddr == OFS_FILL_FREEZE) begin
				fillFreeze_q <= wmerge(fillFreeze_q, pwdata, pstrb);
			end else if (paddr == OFS_TEMP_THR) begin
				tempThr_q <= wmerge(tempThr_q, pwdata, pstrb);
			end else if (paddr == OFS_CONDENSE) begin
				condense_q <= wmerge(condense_q, pwdata, pstrb);
			end
		end
	end

	pps_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick)
	);

	// Step timer restarts on every state change
	pps_timer u_stateTimer (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick),
		.en(1'b1),
		.clr(stateChange),
		.count(stateCnt)
	);

	pps_timer u_pipeTimer (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick),
		.en(pipeCond),
		.clr(1'b0),
		.count(pipeCnt)
	);

	pps_timer u_fillTimer (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick),
		.en(fillHold),
		.clr(1'b0),
		.count(fillCnt)
	);

	pps_timer u_condTimer (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick),
		.en(condRun_q),
		.clr(condRise),
		.count(condCnt)
	);

	// Temperature: unselected sensor or a reading off scale reports zero
	assign tempVal = (ctrl_q[CTRL_SENSOR_LSB +: 2] == 2'b00 || tempRaw < TEMP_MIN || tempRaw > TEMP_MAX)
		? 16'sh0 : tempRaw;
	assign freezeThr = tempThr_q[15:0];
	assign preThr = tempThr_q[31:16];
	assign freezeCond = ctrl_q[CTRL_FREEZE_EN] && freezeArmed_q && tempVal < freezeThr;

	assign cleanTerm = termActive(termFunc_q, termIn, FUNC_PUMP_CLEAN);
	assign condTerm = termActive(termFunc_q, termIn, FUNC_CONDENSE);
	assign condRise = condTerm && !condPrev_q && state_q == ST_IDLE;
	assign condDone = condCnt >= CONDENSE_TICKS;

	// Feedback short of setpoint by the level while pinned at the upper limit
	assign pipeCond = pipeBreak_q[15:0] != 16'h0 && state_q == ST_RUN && runFreq >= upperFreq
		&& pidSetpoint > pidFeedback && (pidSetpoint - pidFeedback) >= pipeBreak_q[15:0];
	assign pipeTrip = pipeCond && pipeCnt >= pipeBreak_q[31:16];

	assign fillHold = state_q == ST_FILL && runFreq == softFill_q[15:0];
	assign fillExit = (fillHold && fillCnt >= softFill_q[31:16])
		|| pidFeedback >= fillFreeze_q[15:0];

	assign stateChange = state_d != state_q;

	always_comb begin
		state_d = state_q;
		if (faultStop) begin
			state_d = ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (runCmd && cleanTerm) begin
						if (!cleanBlock_q) begin
							state_d = ST_CLEAN_FWD;
						end
					end else if (runCmd) begin
						state_d = ctrl_q[CTRL_FILL_EN] ? ST_FILL : ST_RUN;
					end else if (freezeCond && !stopCmd) begin
						state_d = ST_FREEZE;
					end
				end
				ST_CLEAN_FWD: begin
					if (stopCmd) begin
						state_d = ST_IDLE;
					end else if (stateCnt >= cleanDur_q[15:0]) begin
						state_d = ST_CLEAN_DWELL_A;
					end
				end
				ST_CLEAN_DWELL_A: begin
					if (stopCmd) begin
						state_d = ST_IDLE;
					end else if (stateCnt >= cleanDwell_q[15:0]) begin
						state_d = ST_CLEAN_REV;
					end
				end
				ST_CLEAN_REV: begin
					if (stopCmd) begin
						state_d = ST_IDLE;
					end else if (stateCnt >= cleanDur_q[31:16]) begin
						state_d = ST_CLEAN_DWELL_B;
					end
				end
				ST_CLEAN_DWELL_B: begin
					if (stopCmd) begin
						state_d = ST_IDLE;
					end else if (stateCnt >= cleanDwell_q[15:0]) begin
						state_d = (cycle_q + 8'h1 >= cleanDwell_q[23:16]) ? ST_IDLE : ST_CLEAN_FWD;
					end
				end
				ST_FILL: begin
					if (stopCmd) begin
						state_d = ST_IDLE;
					end else if (fillExit) begin
						state_d = ST_RUN;
					end
				end
				ST_RUN: begin
					if (stopCmd || (pipeTrip && ctrl_q[CTRL_PIPE_ACTION])) begin
						state_d = ST_IDLE;
					end
				end
				ST_FREEZE: begin
					if (stopCmd) begin
						state_d = ST_IDLE;
					end else if (runCmd) begin
						state_d = ctrl_q[CTRL_FILL_EN] ? ST_FILL : ST_RUN;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Completed reverse-dwell legs
	always_ff @(posedge clk_sys) begin
		if (rst || !isCleaning(state_q)) begin
			cycle_q <= 8'h0;
		end else if (state_q == ST_CLEAN_DWELL_B && state_d == ST_CLEAN_FWD) begin
			cycle_q <= cycle_q + 8'h1;
		end
	end

	// Set on leaving cleaning; only a later stop while stopped clears it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cleanBlock_q <= 1'b0;
		end else if (isCleaning(state_q) && state_d == ST_IDLE) begin
			cleanBlock_q <= 1'b1;
		end else if (state_q == ST_IDLE && stopCmd) begin
			cleanBlock_q <= 1'b0;
		end
	end

	// Re-arming wins over a coincident stop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			freezeArmed_q <= 1'b1;
		end else if (tempVal > freezeThr) begin
			freezeArmed_q <= 1'b1;
		end else if (state_q == ST_FREEZE && stopCmd) begin
			freezeArmed_q <= 1'b0;
		end
	end

	// Injection only while stopped; a new edge restarts the 40 s window
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			condPrev_q <= 1'b0;
			condRun_q <= 1'b0;
		end else begin
			condPrev_q <= condTerm;
			if (condRise) begin
				condRun_q <= 1'b1;
			end else if (condDone || state_q != ST_IDLE) begin
				condRun_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			motorRun <= 1'b0;
			motorReverse <= 1'b0;
			freqCmd <= '0;
			accelTime <= '0;
			decelTime <= '0;
			pidTakeover <= 1'b0;
			cleanActive <= 1'b0;
			fillActive <= 1'b0;
			freezeSignal <= 1'b0;
		end else begin
			motorRun <= state_d == ST_CLEAN_FWD || state_d == ST_CLEAN_REV || state_d == ST_FILL
				|| state_d == ST_RUN || state_d == ST_FREEZE;
			motorReverse <= state_d == ST_CLEAN_REV;
			cleanActive <= isCleaning(state_d);
			fillActive <= state_d == ST_FILL;
			pidTakeover <= state_d == ST_RUN;
			freezeSignal <= state_d == ST_FREEZE;
			accelTime <= isCleaning(state_d) ? cleanRamp_q[15:0] : '0;
			decelTime <= isCleaning(state_d) ? cleanRamp_q[31:16] : '0;
			case (state_d)
				ST_CLEAN_FWD: freqCmd <= cleanFreq_q[15:0];
				ST_CLEAN_REV: freqCmd <= cleanFreq_q[31:16];
				ST_FILL: freqCmd <= softFill_q[15:0];
				ST_FREEZE: freqCmd <= fillFreeze_q[31:16];
				default: freqCmd <= '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prealarm <= 1'b0;
			pipeBreakAlarm <= 1'b0;
			dcInject <= 1'b0;
			dcLevel <= '0;
			tempReport <= 16'sh0;
		end else begin
			prealarm <= tempVal < preThr;
			pipeBreakAlarm <= pipeTrip;
			dcInject <= condRun_q;
			dcLevel <= condRun_q ? condense_q[15:0] : '0;
			tempReport <= tempVal;
		end
	end
endmodule
`default_nettype wire

// File: pps_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer_chk import pps_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Commands
	input wire logic runCmd,
	input wire logic stopCmd,
	input wire logic faultStop,
	input wire logic [TERM_COUNT-1:0] termIn,
	// Observed outputs
	input wire logic motorRun,
	input wire logic [FIELD_W-1:0] freqCmd,
	input wire logic pidTakeover,
	input wire logic dcInject,
	input wire logic cleanActive,
	input wire logic fillActive,
	input wire logic freezeSignal,
	input wire logic signed [15:0] tempReport
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Slack of two ticks covers the phase of the first tick
	localparam int DC_MAX = (CONDENSE_TICKS + 2) * TICK_CYCLES;
	int dcCnt_q;
	logic [TERM_COUNT-1:0] termIn_q;
	always_ff @(posedge clk_sys) begin
		termIn_q <= termIn;
		if (rst || !dcInject || |(termIn & ~termIn_q)) begin
			dcCnt_q <= 0;
		end else begin
			dcCnt_q <= dcCnt_q + 1;
		end
	end
	property p_cleanStart;
		$rose(cleanActive) |-> $past(runCmd) && $past(|termIn) && !$past(motorRun);
	endproperty
	a_cleanStart: assert property (p_cleanStart) else $error("cleaning began without start");
	property p_dwellZero;
		cleanActive && !motorRun |-> freqCmd == 16'h0000;
	endproperty
	a_dwellZero: assert property (p_dwellZero) else $error("dwell with frequency");
	property p_cleanAbort;
		stopCmd && cleanActive |=> !cleanActive && !motorRun;
	endproperty
	a_cleanAbort: assert property (p_cleanAbort) else $error("stop did not abort cleaning");
	property p_fillExit;
		$fell(fillActive) && motorRun |-> pidTakeover && freqCmd == 16'h0000;
	endproperty
	a_fillExit: assert property (p_fillExit) else $error("fill exit without regulator");
	property p_faultStop;
		faultStop |=> !motorRun && !fillActive;
	endproperty
	a_faultStop: assert property (p_faultStop) else $error("fault did not stop");
	property p_freezeIgnore;
		$rose(freezeSignal) |-> !$past(pidTakeover) && !$past(cleanActive) && !$past(fillActive);
	endproperty
	a_freezeIgnore: assert property (p_freezeIgnore) else $error("freeze while running");
	property p_freezeRun;
		runCmd && !stopCmd && !faultStop && freezeSignal |=> !freezeSignal && motorRun;
	endproperty
	a_freezeRun: assert property (p_freezeRun) else $error("run did not end freeze");
	property p_freezeStop;
		stopCmd && freezeSignal |=> (!freezeSignal && !motorRun) [*3];
	endproperty
	a_freezeStop: assert property (p_freezeStop) else $error("stop did not end freeze");
	property p_tempSpan;
		tempReport >= TEMP_MIN && tempReport <= TEMP_MAX;
	endproperty
	a_tempSpan: assert property (p_tempSpan) else $error("temperature out of span");
	property p_dcBound;
		dcCnt_q <= DC_MAX;
	endproperty
	a_dcBound: assert property (p_dcBound) else $error("injection too long");
	c_cleanDone: cover property ($fell(cleanActive));
	c_pidTake: cover property ($rose(pidTakeover));
	c_freeze: cover property ($rose(freezeSignal));
	c_dcDone: cover property ($fell(dcInject));
endmodule
`default_nettype wire

// File: pps_tick.sv
`timescale 1ns/1ps
`default_nettype none
module pps_tick import pps_pkg::*; #(
	parameter int CYCLES = TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Timebase pulse
	output logic tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_q <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_q >= 32'(CYCLES - 1)) begin
			cnt_q <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: pps_tick_dummy_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: pps_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pps_timer import pps_pkg::*; #(
	parameter int W = TIMER_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic tick,
	input wire logic en,
	input wire logic clr,
	// Elapsed ticks
	output logic [W-1:0] count
);
	// Saturates so a long condition never wraps back below its limit
	always_ff @(posedge clk_sys) begin
		if (rst || !en || clr) begin
			count <= '0;
		end else if (tick && count != {W{1'b1}}) begin
			count <= count + W'(1);
		end
	end
endmodule
`default_nettype wire

// File: pump_protection_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module pump_protection_sequencer_test import pps_pkg::*; ();
	logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic runCmd, stopCmd, faultStop, motorRun, motorReverse, pidTakeover, dcInject;
	logic cleanActive, fillActive, freezeSignal, prealarm, pipeBreakAlarm;
	logic [TERM_COUNT-1:0] termIn;
	logic [FIELD_W-1:0] pidFeedback, pidSetpoint, runFreq, upperFreq, freqCmd, accelTime, decelTime, dcLevel;
	logic signed [15:0] tempRaw, tempReport;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	pps_sequencer #(.TICK_CYCLES(10)) u_pps_sequencer(.*);
	pps_drive_model u_pps_drive_model(.*);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic end_of_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Whole run is about 4500 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input logic r, input logic s);
		@(posedge clk_sys);
		runCmd <= r;
		stopCmd <= s;
		@(posedge clk_sys);
		runCmd <= 1'b0;
		stopCmd <= 1'b0;
		#1;
	endtask
	task automatic t_regs();
		apb(0, OFS_CLEAN_FREQ, 0);
		chk("cleanFreq", RST_CLEAN_FREQ, rd);
		apb(0, OFS_CLEAN_RAMP, 0);
		chk("cleanRamp", RST_CLEAN_RAMP, rd);
		apb(0, OFS_CLEAN_DUR, 0);
		chk("cleanDur", RST_CLEAN_DUR, rd);
		apb(0, OFS_PIPE_BREAK, 0);
		chk("pipeBreak", RST_PIPE_BREAK, rd);
		apb(0, 8'h30, 0);
		chk("unmapped", 1, err);
	endtask
	task automatic t_clean();
		int revs;
		logic prev;
		revs = 0;
		prev = 1'b0;
		apb(1, OFS_TERM_FUNC, 32'h0000_5B56);
		apb(1, OFS_CLEAN_DUR, 32'h0002_0002);
		apb(1, OFS_CLEAN_DWELL, 32'h0002_0002);
		termIn <= 4'h1;
		cmd(1, 0);
		chk("cleanActive", 1, cleanActive);
		chk("fwdFreq", 5000, freqCmd);
		chk("accel", 100, accelTime);
		chk("decel", 100, decelTime);
		for (int i = 0; i < 600 && cleanActive === 1'b1; i++) begin
			waitc(1);
			if (motorReverse === 1'b1 && !prev) begin
				revs++;
				chk("revFreq", 3000, freqCmd);
			end
			prev = motorReverse;
		end
		chk("revCount", 2, revs);
		chk("autoStop", 0, motorRun);
		cmd(1, 0);
		chk("blocked", 0, cleanActive);
		cmd(0, 1);
		cmd(1, 0);
		chk("restart", 1, cleanActive);
		waitc(3);
		cmd(0, 1);
		chk("abort", 0, motorRun);
		@(posedge clk_sys);
		termIn <= 4'h0;
		cmd(0, 1);
	endtask
	task automatic t_fill();
		apb(1, OFS_SOFT_FILL, 32'h0003_0BB8);
		apb(1, OFS_PIPE_BREAK, 32'h0003_0064);
		apb(1, OFS_CTRL, 32'h0000_0003);
		cmd(1, 0);
		chk("fillActive", 1, fillActive);
		chk("fillFreq", 3000, freqCmd);
		waitc(12);
		chk("fillHeld", 1, fillActive);
		for (int i = 0; i < 100 && pidTakeover !== 1'b1; i++) waitc(1);
		chk("fillDone", 1, pidTakeover);
		for (int i = 0; i < 100 && pipeBreakAlarm !== 1'b1; i++) waitc(1);
		chk("pipeAlarm", 1, pipeBreakAlarm);
		waitc(1);
		chk("pipeStop", 0, motorRun);
		cmd(1, 0);
		@(posedge clk_sys);
		faultStop <= 1'b1;
		@(posedge clk_sys);
		faultStop <= 1'b0;
		#1;
		chk("faultStop", 0, fillActive);
		cmd(1, 0);
		chk("refill", 1, fillActive);
		@(posedge clk_sys);
		pidFeedback <= 16'h012C;
		waitc(2);
		chk("cutoff", 1, pidTakeover);
		cmd(0, 1);
		@(posedge clk_sys);
		pidFeedback <= 16'h0064;
	endtask
	task automatic t_freeze();
		apb(1, OFS_CTRL, 32'h0000_0014);
		tempRaw <= 16'hFF9C;
		waitc(3);
		chk("freeze", 1, freezeSignal);
		chk("freezeRun", 1, motorRun);
		chk("prealarm", 1, prealarm);
		chk("tempReport", 32'h0000_FF9C, {16'h0000, tempReport});
		cmd(0, 1);
		waitc(3);
		chk("disarm", 0, freezeSignal);
		@(posedge clk_sys);
		tempRaw <= 16'h0000;
		waitc(3);
		chk("noPrealarm", 0, prealarm);
		@(posedge clk_sys);
		tempRaw <= 16'hFF9C;
		waitc(3);
		chk("rearm", 1, freezeSignal);
		cmd(1, 0);
		chk("runEnds", 0, freezeSignal);
		chk("runCmd", 1, motorRun);
		waitc(3);
		chk("runIgnores", 0, freezeSignal);
		// Action 0: a starved pipe raises the alarm but the motor keeps running
		for (int i = 0; i < 100 && pipeBreakAlarm !== 1'b1; i++) waitc(1);
		chk("pipeAlarm0", 1, pipeBreakAlarm);
		chk("pipeKeep", 1, motorRun);
		// Off-scale reading reads zero, above the threshold, so stop does not refreeze
		@(posedge clk_sys);
		tempRaw <= 16'h09C4;
		waitc(3);
		chk("overRange", 0, {16'h0000, tempReport});
		cmd(0, 1);
		chk("runStop", 0, motorRun);
	endtask
	task automatic t_condense();
		apb(1, OFS_CTRL, 32'h0000_0000);
		termIn <= 4'h2;
		waitc(3);
		chk("dcOn", 1, dcInject);
		chk("dcLevel", 300, dcLevel);
		waitc(3950);
		chk("dcHeld", 1, dcInject);
		for (int i = 0; i < 100 && dcInject !== 1'b0; i++) waitc(1);
		chk("dcOff", 0, dcInject);
		waitc(20);
		chk("noRetrigger", 0, dcInject);
	endtask
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, runCmd, stopCmd, faultStop} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		termIn = 4'h0;
		pidFeedback = 16'h0064;
		pidSetpoint = 16'h01F4;
		upperFreq = 16'h1388;
		tempRaw = 16'h0064;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_clean();
		t_fill();
		t_freeze();
		t_condense();
		end_of_test();
	end
endmodule
bind pps_sequencer pps_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) u_pps_sequencer_chk(.*);
`default_nettype wire
